// ### cci_register_access_slave.sv
// Purpose: two-wire camera control slave giving a bus master access to
//          a 16-bit addressed, byte-wide register space
// Assumes: sensor input clock oversamples SCL by at least the ratio
//          in the package; register space answers reads in one cycle
// Notes: no clock stretching, so read data must cross in time
// Function
// RQ1: six transfer types: reads and writes
// RQ2: master writes address, then repeated start
// RQ3: read address: acknowledge, then shift indexed byte
// RQ4: master ends single read with nack, stop
// RQ5: received register address held in index pointer
// RQ6: index increments at every ack/nack bit; code advances it only at data-byte ack/nack bits, not at address acks
// RQ7: read without address uses held index
// RQ8: master ack advances index, next byte driven
// RQ9: master ends sequential read with nack, stop
// RQ10: single write stores byte at addressed register
// RQ11: write byte acknowledged while index advances
// RQ12: master ends writes with a stop
// RQ13: input clock 11.4-27 MHz allows 1000 kHz
// RQ14: input clock 6-27 MHz limits to 400 kHz
// RQ15: 16-bit address, 8-bit data, MSB first
// RQ16: direction bit 0 write, 1 read
// RQ17: master stops at once after nack
// RQ18: unreadable locations read as zero
// RQ19: address sent upper byte first, each acknowledged
`timescale 1ns/10ps
`default_nettype none
module cci_register_access_slave
    import cci_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_sensor_input_clock,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic [15:0] o_reg_addr,
    output logic [7:0] o_reg_wdata,
    output logic o_reg_write,
    output logic o_reg_read,
    input wire logic [7:0] i_reg_rdata,
    input wire logic i_reg_unreadable
);
    // receive-type states shift SDA in on SCL rise
    function automatic logic is_rx(input cci_state_t s);
        return (s == CCI_DEV) || (s == CCI_AHI) || (s == CCI_ALO) || (s == CCI_WDATA);
    endfunction : is_rx

    logic scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
    logic ack_m_r, ack_s_r;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    cci_state_t state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt, ahi_r, ahi_nxt;
    logic [15:0] idx_r, idx_nxt, req_addr_r, req_addr_nxt;
    logic [7:0] req_data_r, req_data_nxt;
    logic rw_r, rw_nxt, acked_r, acked_nxt, oe_r, oe_nxt;
    logic req_tgl_r, req_tgl_nxt, req_wr_r, req_wr_nxt;
    logic [7:0] rd_byte;
    logic rq_m_r, rq_s_r, rq_d_r, rq_edge;
    logic rd_pend_r, rd_pend_nxt, wr_stb_r, wr_stb_nxt, rd_stb_r, rd_stb_nxt;
    logic ack_tgl_r, ack_tgl_nxt;
    logic [7:0] rdata_r, rdata_nxt, wdata_o_r, wdata_o_nxt;
    logic [15:0] addr_o_r, addr_o_nxt;

    // pin synchronisers; oversampling sets the bus-rate ceiling [RQ13] [RQ14]
    always_ff @(posedge i_sensor_input_clock or posedge i_reset) begin
        if (i_reset) begin
            {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
            {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
            {ack_m_r, ack_s_r} <= 2'h0;
        end else begin
            {scl_m_r, scl_s_r, scl_d_r} <= {i_scl, scl_m_r, scl_s_r};
            {sda_m_r, sda_s_r, sda_d_r} <= {i_sda, sda_m_r, sda_s_r};
            {ack_m_r, ack_s_r} <= {ack_tgl_r, ack_m_r};
        end
    end

    // bus events from the settled samples only
    assign scl_rise = scl_s_r & ~scl_d_r;
    assign scl_fall = ~scl_s_r & scl_d_r;
    assign bus_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
    assign bus_stop = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
    // zero if the core has not answered yet; no stretching to wait
    assign rd_byte = (ack_s_r == req_tgl_r) ? rdata_r : CCI_UNREADABLE_VAL;

    // link protocol next state
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        tx_nxt = tx_r;
        ahi_nxt = ahi_r;
        idx_nxt = idx_r;
        rw_nxt = rw_r;
        acked_nxt = acked_r;
        oe_nxt = oe_r;
        req_tgl_nxt = req_tgl_r;
        req_wr_nxt = req_wr_r;
        req_addr_nxt = req_addr_r;
        req_data_nxt = req_data_r;
        // bytes arrive MSB first [RQ15]
        if (is_rx(state_r) && scl_rise && cnt_r != CCI_BYTE_BITS) begin
            sh_nxt = {sh_r[6:0], sda_s_r};
            cnt_nxt = cnt_r + 4'h1;
        end
        if (bus_start) begin // repeated start keeps the index [RQ2]
            state_nxt = CCI_DEV;
            cnt_nxt = 4'h0;
            oe_nxt = 1'b0;
        end else if (bus_stop) begin
            state_nxt = CCI_IDLE;
            oe_nxt = 1'b0;
        end else begin
            case (state_r)
                CCI_IDLE: begin
                    oe_nxt = 1'b0;
                end
                CCI_DEV: begin
                    if (scl_fall && cnt_r == CCI_BYTE_BITS) begin
                        cnt_nxt = 4'h0;
                        if (sh_r[7:1] == CCI_SLAVE_ADDR) begin
                            state_nxt = CCI_DEV_ACK;
                            oe_nxt = 1'b1; // acknowledge address [RQ3]
                            rw_nxt = sh_r[0]; // 1 reads, 0 writes [RQ16] [RQ1]
                            if (sh_r[0]) begin // fetch from held index [RQ7]
                                req_tgl_nxt = ~req_tgl_r;
                                req_wr_nxt = 1'b0;
                                req_addr_nxt = idx_r;
                            end
                        end else begin
                            state_nxt = CCI_IDLE;
                        end
                    end
                end
                CCI_DEV_ACK: begin
                    if (scl_fall) begin
                        cnt_nxt = 4'h0;
                        if (rw_r) begin // data follows the ack at once [RQ3]
                            state_nxt = CCI_RDATA;
                            tx_nxt = rd_byte;
                            oe_nxt = ~rd_byte[7];
                        end else begin
                            state_nxt = CCI_AHI;
                            oe_nxt = 1'b0;
                        end
                    end
                end
                CCI_AHI: begin
                    if (scl_fall && cnt_r == CCI_BYTE_BITS) begin // upper byte first [RQ19]
                        ahi_nxt = sh_r;
                        state_nxt = CCI_AHI_ACK;
                        oe_nxt = 1'b1;
                        cnt_nxt = 4'h0;
                    end
                end
                CCI_ALO: begin
                    if (scl_fall && cnt_r == CCI_BYTE_BITS) begin
                        idx_nxt = {ahi_r, sh_r}; // index loaded [RQ5]
                        state_nxt = CCI_ALO_ACK;
                        oe_nxt = 1'b1;
                        cnt_nxt = 4'h0;
                    end
                end
                CCI_WDATA: begin
                    if (scl_fall && cnt_r == CCI_BYTE_BITS) begin
                        req_tgl_nxt = ~req_tgl_r; // store at index [RQ10]
                        req_wr_nxt = 1'b1;
                        req_addr_nxt = idx_r;
                        req_data_nxt = sh_r;
                        idx_nxt = idx_r + 16'h0001; // ack and advance together [RQ11] [RQ6]
                        state_nxt = CCI_WDATA_ACK;
                        oe_nxt = 1'b1;
                        cnt_nxt = 4'h0;
                    end
                end
                CCI_AHI_ACK, CCI_ALO_ACK, CCI_WDATA_ACK: begin
                    if (scl_fall) begin
                        state_nxt = (state_r == CCI_AHI_ACK) ? CCI_ALO : CCI_WDATA;
                        oe_nxt = 1'b0;
                        cnt_nxt = 4'h0;
                    end
                end
                CCI_RDATA: begin
                    if (scl_rise) begin
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall && cnt_r == CCI_BYTE_BITS) begin
                        idx_nxt = idx_r + 16'h0001; // advance at ack/nack time [RQ6]
                        state_nxt = CCI_RDATA_ACK;
                        oe_nxt = 1'b0;
                        cnt_nxt = 4'h0;
                    end else if (scl_fall) begin
                        tx_nxt = {tx_r[6:0], 1'b0}; // MSB first [RQ15]
                        oe_nxt = ~tx_r[6];
                    end
                end
                CCI_RDATA_ACK: begin
                    if (scl_rise) begin
                        acked_nxt = ~sda_s_r;
                        if (!sda_s_r) begin // master ack: fetch next [RQ8]
                            req_tgl_nxt = ~req_tgl_r;
                            req_wr_nxt = 1'b0;
                            req_addr_nxt = idx_r;
                        end
                    end else if (scl_fall) begin
                        cnt_nxt = 4'h0;
                        if (acked_r) begin
                            state_nxt = CCI_RDATA;
                            tx_nxt = rd_byte;
                            oe_nxt = ~rd_byte[7];
                        end else begin
                            state_nxt = CCI_IDLE; // nack: wait for the stop [RQ4] [RQ9]
                        end
                    end
                end
                default: begin
                    state_nxt = CCI_IDLE;
                    oe_nxt = 1'b0;
                end
            endcase
        end
    end

    // link protocol registers
    always_ff @(posedge i_sensor_input_clock or posedge i_reset) begin
        if (i_reset) begin
            state_r <= CCI_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            ahi_r <= 8'h00;
            idx_r <= CCI_IDX_RESET;
            rw_r <= 1'b0;
            acked_r <= 1'b0;
            oe_r <= 1'b0;
            req_tgl_r <= 1'b0;
            req_wr_r <= 1'b0;
            req_addr_r <= 16'h0000;
            req_data_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            tx_r <= tx_nxt;
            ahi_r <= ahi_nxt;
            idx_r <= idx_nxt;
            rw_r <= rw_nxt;
            acked_r <= acked_nxt;
            oe_r <= oe_nxt;
            req_tgl_r <= req_tgl_nxt;
            req_wr_r <= req_wr_nxt;
            req_addr_r <= req_addr_nxt;
            req_data_r <= req_data_nxt;
        end
    end

    // open-drain: only ever pull low
    assign o_sda_out = 1'b0;
    assign o_sda_oe = oe_r;

    // request toggle into the core clock; address and data stay still meanwhile
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            {rq_m_r, rq_s_r, rq_d_r} <= 3'h0;
        end else begin
            {rq_m_r, rq_s_r, rq_d_r} <= {req_tgl_r, rq_m_r, rq_s_r};
        end
    end
    assign rq_edge = rq_s_r ^ rq_d_r;

    // register-space access next state
    always_comb begin
        wr_stb_nxt = 1'b0;
        rd_stb_nxt = 1'b0;
        rd_pend_nxt = 1'b0;
        ack_tgl_nxt = ack_tgl_r;
        rdata_nxt = rdata_r;
        addr_o_nxt = addr_o_r;
        wdata_o_nxt = wdata_o_r;
        if (rq_edge) begin
            addr_o_nxt = req_addr_r;
            wdata_o_nxt = req_data_r;
            wr_stb_nxt = req_wr_r; // [RQ10]
            rd_stb_nxt = ~req_wr_r;
            rd_pend_nxt = ~req_wr_r;
            if (req_wr_r) begin
                ack_tgl_nxt = ~ack_tgl_r;
            end
        end
        if (rd_pend_r) begin
            rdata_nxt = i_reg_unreadable ? CCI_UNREADABLE_VAL : i_reg_rdata; // [RQ18]
            ack_tgl_nxt = ~ack_tgl_r;
        end
    end

    // register-space access registers
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            wr_stb_r <= 1'b0;
            rd_stb_r <= 1'b0;
            rd_pend_r <= 1'b0;
            ack_tgl_r <= 1'b0;
            rdata_r <= 8'h00;
            addr_o_r <= 16'h0000;
            wdata_o_r <= 8'h00;
        end else begin
            wr_stb_r <= wr_stb_nxt;
            rd_stb_r <= rd_stb_nxt;
            rd_pend_r <= rd_pend_nxt;
            ack_tgl_r <= ack_tgl_nxt;
            rdata_r <= rdata_nxt;
            addr_o_r <= addr_o_nxt;
            wdata_o_r <= wdata_o_nxt;
        end
    end

    assign o_reg_addr = addr_o_r;
    assign o_reg_wdata = wdata_o_r;
    assign o_reg_write = wr_stb_r;
    assign o_reg_read = rd_stb_r;

    // checks on the link side and the core side
    sequence s_addr_match;
        state_r == CCI_DEV && scl_fall && !bus_start && !bus_stop &&
            cnt_r == CCI_BYTE_BITS && sh_r[7:1] == CCI_SLAVE_ADDR;
    endsequence
    sequence s_wbyte_end;
        state_r == CCI_WDATA && scl_fall && !bus_start && !bus_stop && cnt_r == CCI_BYTE_BITS;
    endsequence
    sequence s_rbyte_end;
        state_r == CCI_RDATA && scl_fall && !bus_start && !bus_stop && cnt_r == CCI_BYTE_BITS;
    endsequence

    AST_ADDR_ACK: assert property (@(posedge i_sensor_input_clock) disable iff (i_reset) // [RQ3]
        s_addr_match |=> o_sda_oe && state_r == CCI_DEV_ACK)
        else $error("address match not acknowledged");
    AST_DIR_BIT: assert property (@(posedge i_sensor_input_clock) disable iff (i_reset) // [RQ16]
        s_addr_match |=> rw_r == $past(sh_r[0]))
        else $error("direction bit misread");
    AST_INDEX_LOAD: assert property (@(posedge i_sensor_input_clock) disable iff (i_reset) // [RQ5]
        (state_r == CCI_ALO && scl_fall && !bus_start && !bus_stop && cnt_r == CCI_BYTE_BITS)
        |=> idx_r == {ahi_r, $past(sh_r)})
        else $error("index not loaded from address bytes");
    AST_WR_ADVANCE: assert property (@(posedge i_sensor_input_clock) disable iff (i_reset) // [RQ11]
        s_wbyte_end |=> idx_r == $past(idx_r) + 16'h0001 && o_sda_oe && req_wr_r)
        else $error("write byte did not ack and advance");
    AST_RD_ADVANCE: assert property (@(posedge i_sensor_input_clock) disable iff (i_reset) // [RQ6]
        s_rbyte_end |=> idx_r == $past(idx_r) + 16'h0001 && !o_sda_oe)
        else $error("read byte did not advance index");
    AST_SEQ_FETCH: assert property (@(posedge i_sensor_input_clock) disable iff (i_reset) // [RQ8]
        (state_r == CCI_RDATA_ACK && scl_rise && !sda_s_r && !bus_start && !bus_stop)
        |=> req_tgl_r != $past(req_tgl_r) && !req_wr_r && req_addr_r == idx_r)
        else $error("master ack did not fetch next byte");
    AST_MSB_FIRST: assert property (@(posedge i_sensor_input_clock) disable iff (i_reset) // [RQ15]
        (state_r == CCI_RDATA && scl_fall && !bus_start && !bus_stop && cnt_r != CCI_BYTE_BITS)
        |=> o_sda_oe == ~tx_r[7] && tx_r[0] == 1'b0)
        else $error("read bit order wrong");
    AST_WR_STROBE: assert property (@(posedge i_clock) disable iff (i_reset) // [RQ10]
        (rq_edge && req_wr_r) |=> o_reg_write ##1 !o_reg_write)
        else $error("write strobe not a single pulse");
    AST_UNREADABLE: assert property (@(posedge i_clock) disable iff (i_reset) // [RQ18]
        (rd_pend_r && i_reg_unreadable) |=> rdata_r == CCI_UNREADABLE_VAL)
        else $error("unreadable location gave nonzero data");
endmodule : cci_register_access_slave
`default_nettype wire

// ### cci_pkg.sv
// Purpose: shared constants for the camera control two-wire slave
// Assumes: 16-bit register index, byte-wide data, 7-bit slave address
// Notes: bus-rate limits are kept here as figures and derived ratios
package cci_pkg;
    // 7-bit bus address of this slave (arbitrary value)
    localparam logic [6:0] CCI_SLAVE_ADDR = 7'h10;
    localparam logic [3:0] CCI_BYTE_BITS = 4'h8;
    localparam logic [15:0] CCI_IDX_RESET = 16'h0000;
    localparam logic [7:0] CCI_UNREADABLE_VAL = 8'h00;
    // bus-rate limits against the sensor input clock, in kHz
    localparam int CCI_FMP_SENSOR_INPUT_CLOCK_MIN_KHZ = 11400;
    localparam int CCI_FMP_SCL_MAX_KHZ = 1000;
    localparam int CCI_FM_SENSOR_INPUT_CLOCK_MIN_KHZ = 6000;
    localparam int CCI_FM_SCL_MAX_KHZ = 400;
    // least sensor clocks per bus bit at each limit, rounded down
    localparam int CCI_FMP_CYC_PER_BIT = CCI_FMP_SENSOR_INPUT_CLOCK_MIN_KHZ / CCI_FMP_SCL_MAX_KHZ;
    localparam int CCI_FM_CYC_PER_BIT = CCI_FM_SENSOR_INPUT_CLOCK_MIN_KHZ / CCI_FM_SCL_MAX_KHZ;
    // link-side protocol states
    typedef enum logic [3:0] {
        CCI_IDLE, CCI_DEV, CCI_DEV_ACK, CCI_AHI, CCI_AHI_ACK, CCI_ALO, CCI_ALO_ACK,
        CCI_WDATA, CCI_WDATA_ACK, CCI_RDATA, CCI_RDATA_ACK
    } cci_state_t;
endpackage : cci_pkg

// ### cci_bus_master.sv
// Purpose: behavioural two-wire bus master facing the camera control slave
// Assumes: 400 kHz bit timing, pull-up on the data line, push-pull clock
// Notes: clock idles high between frames; data is only ever pulled low
`timescale 1ns/10ps
`default_nettype none
module cci_bus_master (
    input wire logic i_sda_line,
    output logic o_scl,
    output logic o_sda_pull
);
    // low and high phases kept above the fast-mode minimum
    localparam int T_Q = 300;
    localparam int T_LOW = 1300;
    localparam int T_HIGH = 1200;

    // bus idle after power-up
    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end

    // data moves only while the clock is low, rate 400 kHz
    task automatic send_bit(input logic b);
        #T_Q o_sda_pull = ~b;
        #(T_LOW - T_Q) o_scl = 1'b1;
        #T_HIGH o_scl = 1'b0;
    endtask : send_bit

    // release the line, sample in mid-high
    task automatic recv_bit(output logic b);
        #T_Q o_sda_pull = 1'b0;
        #(T_LOW - T_Q) o_scl = 1'b1;
        #(T_HIGH / 2) b = i_sda_line;
        #(T_HIGH / 2) o_scl = 1'b0;
    endtask : recv_bit

    // repeated start when the clock is low, no stop in between
    task automatic start();
        if (!o_scl) begin
            #T_Q o_sda_pull = 1'b0;
            #(T_LOW - T_Q) o_scl = 1'b1;
            #(T_HIGH / 2);
        end
        o_sda_pull = 1'b1;
        #(T_HIGH / 2) o_scl = 1'b0;
    endtask : start

    // ends every transfer, also at once after any nack
    task automatic stop();
        #T_Q o_sda_pull = 1'b1;
        #(T_LOW - T_Q) o_scl = 1'b1;
        #(T_HIGH / 2) o_sda_pull = 1'b0;
        #T_LOW;
    endtask : stop

    // byte out msb first; returns the ninth bit, 0 meaning ack
    task automatic write_byte(input logic [7:0] d, output logic nak);
        for (int i = 7; i >= 0; i--) begin
            send_bit(d[i]);
        end
        recv_bit(nak);
    endtask : write_byte

    // byte in msb first; nack on the last wanted byte
    task automatic read_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            recv_bit(d[i]);
        end
        send_bit(last);
    endtask : read_byte
endmodule : cci_bus_master
`default_nettype wire

// ### cci_register_access_slave_bench.sv
// Purpose: self-checking bench for the camera control two-wire slave
// Assumes: register space modelled here, 0x2axx locations unreadable
// Notes: link clock 80 ns, free of phase ties to the 20 ns core clock
`timescale 1ns/10ps
`default_nettype none
module cci_register_access_slave_bench
    import cci_pkg::*;
;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic link_clock = 1'b0;
    logic scl, m_pull, sda_line, sda_out, sda_oe, reg_write, reg_read;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic reg_unreadable;
    logic [7:0] mem [0:65535];
    logic [23:0] wlog [$];
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    int rd_pulses = 0;

    // clocks: link clock offset so edges never line up
    always #10 clock = ~clock;
    initial #7 forever #40 link_clock = ~link_clock;

    // open-drain data wire with pull-up
    assign sda_line = ~(m_pull | (sda_oe & ~sda_out));
    // register space answers in the read cycle
    assign reg_rdata = mem[reg_addr];
    assign reg_unreadable = (reg_addr[15:8] === 8'h2a);

    cci_bus_master bm (.i_sda_line(sda_line), .o_scl(scl), .o_sda_pull(m_pull));

    cci_register_access_slave cci_register_access_slave_i (
        .i_clock(clock), .i_reset(reset), .i_sensor_input_clock(link_clock),
        .i_scl(scl), .i_sda(sda_line), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .o_reg_write(reg_write),
        .o_reg_read(reg_read), .i_reg_rdata(reg_rdata), .i_reg_unreadable(reg_unreadable)
    );

    // store writes, log them, and cut a hang short
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (reg_write === 1'b1) begin
            mem[reg_addr] <= reg_wdata;
            wlog.push_back({reg_addr, reg_wdata});
        end
        // one read strobe expected per byte handed to the master
        if (reg_read === 1'b1) begin
            rd_pulses <= rd_pulses + 1;
        end
        if (cycles == 90000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val

    task automatic check_ack(input logic got, input logic exp);
        check_val({23'd0, got}, {23'd0, exp});
    endtask : check_ack

    // unreadable locations must read back as zero
    function automatic logic [7:0] exp_rd(input logic [15:0] a);
        return (a[15:8] === 8'h2a) ? 8'h00 : mem[a];
    endfunction : exp_rd

    // device address write, index upper then lower, no stop
    task automatic send_index(input logic [15:0] a);
        logic nak;
        bm.start();
        bm.write_byte({CCI_SLAVE_ADDR, 1'b0}, nak);
        check_ack(nak, 1'b0);
        bm.write_byte(a[15:8], nak);
        check_ack(nak, 1'b0);
        bm.write_byte(a[7:0], nak);
        check_ack(nak, 1'b0);
    endtask : send_index

    // n data bytes from address a, each checked at the core side
    task automatic write_run(input logic [15:0] a, input int n);
        logic nak;
        logic [7:0] d;
        send_index(a);
        for (int i = 0; i < n; i++) begin
            d = 8'(i) + 8'h5a;
            bm.write_byte(d, nak);
            check_ack(nak, 1'b0);
            for (int k = 0; k < 100 && wlog.size() == 0; k++) begin
                @(posedge clock);
            end
            check_val(wlog.size() ? wlog.pop_front() : 'x, {a + 16'(i), d});
        end
        bm.stop();
    endtask : write_run

    // n bytes from a, optionally after loading the index first
    task automatic read_run(input logic [15:0] a, input int n, input logic new_loc);
        logic nak;
        logic [7:0] d;
        int p0;
        p0 = rd_pulses;
        if (new_loc) begin
            send_index(a);
        end
        bm.start();
        bm.write_byte({CCI_SLAVE_ADDR, 1'b1}, nak);
        check_ack(nak, 1'b0);
        for (int i = 0; i < n; i++) begin
            bm.read_byte(i == n - 1, d);
            check_val({16'd0, d}, {16'd0, exp_rd(a + 16'(i))});
        end
        check_val(24'(rd_pulses - p0), 24'(n));
        bm.stop();
    endtask : read_run

    task automatic t_reset();
        repeat (4) @(posedge clock);
        check_val({sda_oe, reg_write, reg_read, reg_addr}, '0);
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        repeat (20) @(posedge clock);
    endtask : t_reset

    // wrong device address: no ack, index untouched afterwards
    task automatic t_wrong_addr();
        logic nak;
        bm.start();
        bm.write_byte({CCI_SLAVE_ADDR ^ 7'h01, 1'b0}, nak);
        check_ack(nak, 1'b1);
        bm.stop();
        read_run(16'h0205, 1, 1'b0);
    endtask : t_wrong_addr

    task automatic wrap_up();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    // the six transfer kinds, boundary crossings and refusals
    initial begin
        for (int a = 0; a < 65536; a++) begin
            mem[a] = 8'(a) ^ 8'(a >> 8) ^ 8'h3c;
        end
        t_reset();
        write_run(16'h0012, 1);
        write_run(16'h01fe, 3);
        read_run(16'h0012, 1, 1'b1);
        read_run(16'h0013, 1, 1'b0);
        read_run(16'h0014, 1, 1'b0);
        read_run(16'h01fd, 5, 1'b1);
        read_run(16'h0202, 3, 1'b0);
        t_wrong_addr();
        read_run(16'h2a00, 2, 1'b1);
        wrap_up();
    end
endmodule : cci_register_access_slave_bench
`default_nettype wire
